/* lsbe_pkg.sv */
// Package for the carry-AND, arithmetic shift and carry-clear branch unit
package lsbe_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_RF_LAST = 8'h1C;
  localparam logic [7:0] OFF_CMD     = 8'h20;
  localparam logic [7:0] OFF_FLAGS   = 8'h24;
  localparam logic [7:0] OFF_PC      = 8'h28;
  localparam logic [7:0] OFF_STATUS  = 8'h2C;

  // Operation codes
  localparam logic [2:0] OP_AND_CARRY_BIT     = 3'h0;
  localparam logic [2:0] OP_AND_CARRY_INV_BIT = 3'h1;
  localparam logic [2:0] OP_ARITH_SHIFT_LEFT  = 3'h2;
  localparam logic [2:0] OP_ARITH_SHIFT_RIGHT = 3'h3;
  localparam logic [2:0] OP_BRANCH_CARRY_CLR  = 3'h4;

  // size_field encodings
  localparam logic [1:0] SIZE_BYTE  = 2'h0;
  localparam logic [1:0] SIZE_WORD  = 2'h2;
  localparam logic [1:0] SIZE_DWORD = 2'h3;

  localparam logic [4:0] MSB_BYTE  = 5'h07;
  localparam logic [4:0] MSB_WORD  = 5'h0F;
  localparam logic [4:0] MSB_DWORD = 5'h1F;

  // Clock counts per instruction
  localparam logic [7:0] CLK_CARRY_BIT   = 8'h04;
  localparam logic [7:0] CLK_SHIFT_SHORT = 8'h04;
  localparam logic [7:0] CLK_SHIFT_LONG  = 8'h06;
  localparam logic [7:0] CLK_BRANCH_TKN  = 8'h06;
  localparam logic [7:0] CLK_BRANCH_NOT  = 8'h03;

  // Bit addresses below this limit map onto the register file
  localparam logic [9:0]  BIT_RF_LIMIT = 10'h080;
  localparam logic [15:0] PC_STEP      = 16'h0002;
  localparam logic [15:0] PC_ALIGN     = 16'hFFFE;

  // Status bit positions
  localparam int ST_BUSY  = 0;
  localparam int ST_TAKEN = 1;
  localparam int ST_ERR   = 2;

  typedef struct packed {
    logic [15:0] arg;
    logic        rsv_a;
    logic [2:0]  src;
    logic        rsv_b;
    logic [2:0]  dst;
    logic        rsv_c;
    logic        cnt_reg;
    logic [1:0]  size;
    logic        rsv_d;
    logic [2:0]  op;
  } lsbe_cmd_type;

  typedef struct packed {
    logic z;
    logic n;
    logic v;
    logic c;
  } lsbe_flags_type;

  typedef struct packed {
    logic [31:0] val;
    logic        c;
    logic        v;
  } lsbe_step_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } lsbe_state_type;

  function automatic logic [4:0] msb_of(input logic [1:0] sz);
    logic [4:0] m;
    unique case (sz)
      SIZE_BYTE: m = MSB_BYTE;
      SIZE_WORD: m = MSB_WORD;
      default:   m = MSB_DWORD;
    endcase
    return m;
  endfunction : msb_of

  function automatic logic [31:0] size_mask(input logic [1:0] sz);
    return 32'hFFFFFFFF >> (MSB_DWORD - msb_of(sz));
  endfunction : size_mask

  // One bit position of an arithmetic shift
  function automatic lsbe_step_type shift_step(input logic [31:0] val,
                                                input logic [1:0]  sz,
                                                input logic        left);
    lsbe_step_type s;
    logic [4:0]    m;
    m = msb_of(sz);
    if (left) begin
      s.c      = val[m];
      s.val    = (val << 1) & size_mask(sz);
      s.v      = s.val[m] ^ val[m];
    end else begin
      s.c      = val[0];
      s.val    = val >> 1;
      s.val[m] = val[m];
      s.v      = 1'b0;
    end
    return s;
  endfunction : shift_step

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

endpackage : lsbe_pkg

/* lsbe_exec.sv */
// Execution unit: carry-AND with bit, arithmetic shifts, branch on carry clear
//
// Summary of operation
// RULE1 - carry becomes carry AND addressed bit
// RULE2 - carry becomes carry AND inverted addressed bit
// RULE3 - carry-AND ops: 3 bytes, 4 clocks, 10-bit address
// RULE4 - carry-AND ops touch no other flag
// RULE5 - left shift fills low bits with zeros
// RULE6 - left shift: carry holds last msb out
// RULE7 - zero count leaves destination unshifted
// RULE8 - immediate count: 4 bits, or 5 for dword
// RULE9 - register count uses only low 5 bits
// RULE10 - size field 00 byte, 10 word, 11 dword
// RULE11 - dword shift uses aligned pair, named low
// RULE12 - count operand never modified by shift
// RULE13 - overflow sticky on any sign change, else cleared
// RULE14 - left shift updates carry, overflow, negative, zero
// RULE15 - shift clocks 4 or 6 plus count/2
// RULE16 - right shift refills top with sign
// RULE17 - right shift: carry holds last bit0 out
// RULE18 - right shift keeps overflow unchanged
// RULE19 - branch taken only when carry clear
// RULE20 - pc plus 2, plus twice disp, bit0 cleared
// RULE21 - branch window +254 to -256, word aligned
// RULE22 - shifts set negative from msb, zero on zero
`timescale 1ns/1ps

module lsbe_exec (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             busy_o
);

  // Bus slave state
  logic [31:0] next_dat;
  logic        next_ack;

  // Core state
  logic [15:0]            rf [8];
  logic [15:0]            next_rf [8];
  lsbe_pkg::lsbe_flags_type flg;
  lsbe_pkg::lsbe_flags_type next_flg;
  logic [15:0]            pc;
  logic [15:0]            next_pc;
  lsbe_pkg::lsbe_state_type state;
  lsbe_pkg::lsbe_state_type next_state;
  lsbe_pkg::lsbe_cmd_type   cmd_q;
  lsbe_pkg::lsbe_cmd_type   next_cmd_q;
  logic [7:0]             cyc_left;
  logic [7:0]             next_cyc_left;
  logic [4:0]             rem;
  logic [4:0]             next_rem;
  logic [4:0]             count_q;
  logic [4:0]             next_count_q;
  logic [31:0]            work;
  logic [31:0]            next_work;
  logic [31:0]            orig_q;
  logic [31:0]            next_orig_q;
  logic                   cacc;
  logic                   next_cacc;
  logic                   vacc;
  logic                   next_vacc;
  logic                   bitv_q;
  logic                   next_bitv_q;
  logic                   taken;
  logic                   next_taken;
  logic                   err;
  logic                   next_err;
  logic                   next_busy;

  // Decode helpers
  logic                   wr_take;
  logic                   start;
  logic                   commit;
  logic                   is_shift;
  lsbe_pkg::lsbe_cmd_type   cmd_in;
  logic [2:0]             dlo;
  logic [2:0]             dhi;
  logic [4:0]             cnt_in;
  logic [9:0]             bit_adr;
  logic [4:0]             msb_q;
  logic [31:0]            mask_q;

  always_comb begin
    cmd_in   = lsbe_pkg::lsbe_cmd_type'(wb_dat_i);
    wr_take  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    is_shift = (cmd_in.op == lsbe_pkg::OP_ARITH_SHIFT_LEFT) ||
               (cmd_in.op == lsbe_pkg::OP_ARITH_SHIFT_RIGHT);
    start    = wr_take && (wb_adr_i == lsbe_pkg::OFF_CMD) && (state == lsbe_pkg::ST_IDLE) &&
               (wb_sel_i == 4'hF);
    commit   = (state == lsbe_pkg::ST_EXEC) && (cyc_left == 8'h01);
    // Dword names the low half of an aligned pair
    dlo      = {cmd_in.dst[2:1], 1'b0}; // [RULE11]
    dhi      = {cmd_in.dst[2:1], 1'b1}; // [RULE11]
    bit_adr  = cmd_in.arg[9:0]; // [RULE3]
    msb_q    = lsbe_pkg::msb_of(cmd_q.size);
    mask_q   = lsbe_pkg::size_mask(cmd_q.size);
    if (cmd_in.cnt_reg) begin
      cnt_in = rf[cmd_in.src][4:0]; // [RULE9]
    end else if (cmd_in.size == lsbe_pkg::SIZE_DWORD) begin
      cnt_in = cmd_in.arg[4:0]; // [RULE8]
    end else begin
      cnt_in = {1'b0, cmd_in.arg[3:0]}; // [RULE8]
    end
  end

  // Bus slave: ack one cycle after request, dropped the cycle after
  always_comb begin
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat = wb_dat_o;
    if (next_ack && !wb_we_i) begin
      next_dat = 32'h0;
      if (wb_adr_i <= lsbe_pkg::OFF_RF_LAST) begin
        next_dat = {16'h0, rf[wb_adr_i[4:2]]};
      end else if (wb_adr_i == lsbe_pkg::OFF_CMD) begin
        next_dat = cmd_q;
      end else if (wb_adr_i == lsbe_pkg::OFF_FLAGS) begin
        next_dat = {28'h0, flg};
      end else if (wb_adr_i == lsbe_pkg::OFF_PC) begin
        next_dat = {16'h0, pc};
      end else if (wb_adr_i == lsbe_pkg::OFF_STATUS) begin
        next_dat[lsbe_pkg::ST_BUSY]  = busy_o;
        next_dat[lsbe_pkg::ST_TAKEN] = taken;
        next_dat[lsbe_pkg::ST_ERR]   = err;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // Core next-state logic
  always_comb begin
    lsbe_pkg::lsbe_step_type st;
    logic [31:0] tmp;
    logic [15:0] disp;
    st            = '0;
    tmp           = 32'h0;
    disp          = 16'h0;
    next_rf       = rf;
    next_flg      = flg;
    next_pc       = pc;
    next_state    = state;
    next_cmd_q    = cmd_q;
    next_cyc_left = cyc_left;
    next_rem      = rem;
    next_count_q  = count_q;
    next_work     = work;
    next_orig_q   = orig_q;
    next_cacc     = cacc;
    next_vacc     = vacc;
    next_bitv_q   = bitv_q;
    next_taken    = taken;
    next_err      = err;

    // Software writes only while idle
    if (wr_take && (state == lsbe_pkg::ST_IDLE)) begin
      if (wb_adr_i <= lsbe_pkg::OFF_RF_LAST) begin
        tmp = lsbe_pkg::lane_merge({16'h0, rf[wb_adr_i[4:2]]}, wb_dat_i, wb_sel_i);
        next_rf[wb_adr_i[4:2]] = tmp[15:0];
      end else if (wb_adr_i == lsbe_pkg::OFF_FLAGS) begin
        tmp = lsbe_pkg::lane_merge({28'h0, flg}, wb_dat_i, wb_sel_i);
        next_flg = tmp[3:0];
      end else if (wb_adr_i == lsbe_pkg::OFF_PC) begin
        tmp = lsbe_pkg::lane_merge({16'h0, pc}, wb_dat_i, wb_sel_i);
        next_pc = tmp[15:0];
      end
    end

    if (start) begin
      next_cmd_q = cmd_in;
      if (is_shift && (cmd_in.size != lsbe_pkg::SIZE_BYTE) &&
          (cmd_in.size != lsbe_pkg::SIZE_WORD) && (cmd_in.size != lsbe_pkg::SIZE_DWORD)) begin
        next_err = 1'b1; // [RULE10]
      end else begin
        next_err   = 1'b0;
        next_state = lsbe_pkg::ST_EXEC;
        next_cacc  = flg.c;
        next_vacc  = 1'b0;
        unique case (cmd_in.size)
          lsbe_pkg::SIZE_BYTE: tmp = {24'h0, rf[cmd_in.dst][7:0]}; // [RULE10]
          lsbe_pkg::SIZE_WORD: tmp = {16'h0, rf[cmd_in.dst]};      // [RULE10]
          default:             tmp = {rf[dhi], rf[dlo]};           // [RULE11]
        endcase
        next_work    = tmp;
        next_orig_q  = tmp;
        next_count_q = cnt_in;
        next_rem     = cnt_in;
        next_bitv_q  = (bit_adr < lsbe_pkg::BIT_RF_LIMIT) ?
                       rf[bit_adr[6:4]][bit_adr[3:0]] : 1'b0;
        if (is_shift && (cmd_in.size == lsbe_pkg::SIZE_DWORD)) begin
          next_cyc_left = lsbe_pkg::CLK_SHIFT_LONG + {4'h0, cnt_in[4:1]};  // [RULE15]
        end else if (is_shift) begin
          next_cyc_left = lsbe_pkg::CLK_SHIFT_SHORT + {4'h0, cnt_in[4:1]}; // [RULE15]
        end else if (cmd_in.op == lsbe_pkg::OP_BRANCH_CARRY_CLR) begin
          next_cyc_left = flg.c ? lsbe_pkg::CLK_BRANCH_NOT : lsbe_pkg::CLK_BRANCH_TKN;
        end else begin
          next_cyc_left = lsbe_pkg::CLK_CARRY_BIT; // [RULE3]
        end
      end
    end

    if (state == lsbe_pkg::ST_EXEC) begin
      next_cyc_left = cyc_left - 8'h01;
      // Up to two bit positions per clock
      tmp = work;
      for (int i = 0; i < 2; i++) begin
        if ((i == 0 && rem != 5'h0) || (i == 1 && rem > 5'h1)) begin // [RULE7]
          st   = lsbe_pkg::shift_step(tmp, cmd_q.size,
                                      cmd_q.op == lsbe_pkg::OP_ARITH_SHIFT_LEFT); // [RULE5]
          tmp  = st.val;            // [RULE16]
          next_cacc = st.c;         // [RULE6] [RULE17]
          next_vacc = next_vacc | st.v; // [RULE13]
        end
      end
      if (cmd_q.op == lsbe_pkg::OP_ARITH_SHIFT_LEFT ||
          cmd_q.op == lsbe_pkg::OP_ARITH_SHIFT_RIGHT) begin
        next_work = tmp;
        next_rem  = (rem > 5'h1) ? rem - 5'h2 : 5'h0;
      end
      if (commit) begin
        next_state = lsbe_pkg::ST_IDLE;
        unique case (cmd_q.op)
          lsbe_pkg::OP_AND_CARRY_BIT:     next_flg.c = flg.c & bitv_q;  // [RULE1] [RULE4]
          lsbe_pkg::OP_AND_CARRY_INV_BIT: next_flg.c = flg.c & ~bitv_q; // [RULE2] [RULE4]
          lsbe_pkg::OP_BRANCH_CARRY_CLR: begin
            disp = {{7{cmd_q.arg[7]}}, cmd_q.arg[7:0], 1'b0}; // [RULE21]
            next_taken = !flg.c; // [RULE19]
            next_pc    = pc + lsbe_pkg::PC_STEP; // [RULE20]
            if (!flg.c) begin
              next_pc = (pc + lsbe_pkg::PC_STEP + disp) & lsbe_pkg::PC_ALIGN; // [RULE20]
            end
          end
          default: begin
            // Count register left alone, only destination written
            next_flg.c = cacc; // [RULE14] [RULE12]
            if (cmd_q.op == lsbe_pkg::OP_ARITH_SHIFT_LEFT) begin // [RULE18]
              next_flg.v = vacc; // [RULE13]
            end
            next_flg.n = work[msb_q];                  // [RULE22]
            next_flg.z = ((work & mask_q) == 32'h0);   // [RULE22]
            unique case (cmd_q.size)
              lsbe_pkg::SIZE_BYTE: next_rf[cmd_q.dst][7:0] = work[7:0];
              lsbe_pkg::SIZE_WORD: next_rf[cmd_q.dst] = work[15:0];
              default: begin
                next_rf[{cmd_q.dst[2:1], 1'b0}] = work[15:0];  // [RULE11]
                next_rf[{cmd_q.dst[2:1], 1'b1}] = work[31:16]; // [RULE11]
              end
            endcase
          end
        endcase
      end
    end
    next_busy = (next_state == lsbe_pkg::ST_EXEC);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        rf[i] <= 16'h0;
      end
      flg      <= '0;
      pc       <= 16'h0;
      state    <= lsbe_pkg::ST_IDLE;
      cmd_q    <= '0;
      cyc_left <= 8'h0;
      rem      <= 5'h0;
      count_q  <= 5'h0;
      work     <= 32'h0;
      orig_q   <= 32'h0;
      cacc     <= 1'b0;
      vacc     <= 1'b0;
      bitv_q   <= 1'b0;
      taken    <= 1'b0;
      err      <= 1'b0;
      busy_o   <= 1'b0;
    end else begin
      rf       <= next_rf;
      flg      <= next_flg;
      pc       <= next_pc;
      state    <= next_state;
      cmd_q    <= next_cmd_q;
      cyc_left <= next_cyc_left;
      rem      <= next_rem;
      count_q  <= next_count_q;
      work     <= next_work;
      orig_q   <= next_orig_q;
      cacc     <= next_cacc;
      vacc     <= next_vacc;
      bitv_q   <= next_bitv_q;
      taken    <= next_taken;
      err      <= next_err;
      busy_o   <= next_busy;
    end
  end

  // Checking helpers
  logic [5:0]  out_idx;
  logic        c_expect;
  logic [31:0] low_mask;
  logic        is_asl_q;
  logic        is_asr_q;
  logic        is_bit_q;
  assign is_asl_q = (cmd_q.op == lsbe_pkg::OP_ARITH_SHIFT_LEFT);
  assign is_asr_q = (cmd_q.op == lsbe_pkg::OP_ARITH_SHIFT_RIGHT);
  assign is_bit_q = (cmd_q.op == lsbe_pkg::OP_AND_CARRY_BIT) ||
                    (cmd_q.op == lsbe_pkg::OP_AND_CARRY_INV_BIT);
  assign out_idx  = {1'b0, msb_q} + 6'h01 - {1'b0, count_q};
  assign c_expect = orig_q[out_idx[4:0]];
  assign low_mask = ~(32'hFFFFFFFF << count_q);

  chk_carry_and_bit: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    commit && cmd_q.op == lsbe_pkg::OP_AND_CARRY_BIT |=> flg.c == $past(flg.c & bitv_q))
    else $error("carry-AND with bit gave wrong carry");
  chk_carry_and_inv: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    commit && cmd_q.op == lsbe_pkg::OP_AND_CARRY_INV_BIT |=> flg.c == $past(flg.c & ~bitv_q))
    else $error("carry-AND with inverted bit gave wrong carry");
  chk_bit_op_clocks: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    start && (cmd_in.op == lsbe_pkg::OP_AND_CARRY_BIT) |=> busy_o [*4] ##1 !busy_o)
    else $error("carry-AND bit op not four clocks");
  chk_bit_other_flags: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    commit && is_bit_q |=> $stable(flg.v) && $stable(flg.n) && $stable(flg.z))
    else $error("carry-AND bit op touched other flags");
  chk_asl_zero_fill: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
    commit && is_asl_q |-> (work & low_mask) == 32'h0)
    else $error("left shift low bits not zero");
  chk_asl_carry_out: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
    commit && is_asl_q && count_q != 5'h0 && {1'b0, count_q} <= {1'b0, msb_q} + 6'h01
    |=> flg.c == $past(c_expect))
    else $error("left shift carry not last bit out");
  chk_zero_count: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    commit && (is_asl_q || is_asr_q) && count_q == 5'h0 |-> work == orig_q)
    else $error("zero count changed destination");
  chk_reg_count_low: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
    start && cmd_in.cnt_reg && cmd_in.op == lsbe_pkg::OP_ARITH_SHIFT_RIGHT
    |=> count_q == $past(rf[cmd_in.src][4:0]))
    else $error("register count not truncated to five bits");
  chk_shift_clocks: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE15]
    start && cmd_in.op == lsbe_pkg::OP_ARITH_SHIFT_LEFT && cmd_in.size == lsbe_pkg::SIZE_WORD &&
    !cmd_in.cnt_reg && cmd_in.arg[3:0] == 4'h4 |=> busy_o [*6] ##1 !busy_o)
    else $error("word shift by four not six clocks");
  chk_asr_sign_fill: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
    commit && is_asr_q |-> work[msb_q] == orig_q[msb_q])
    else $error("right shift lost sign bit");
  chk_asr_keeps_v: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE18]
    commit && is_asr_q |=> $stable(flg.v))
    else $error("right shift changed overflow");
  chk_branch_target: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE20]
    start && cmd_in.op == lsbe_pkg::OP_BRANCH_CARRY_CLR && flg.c
    |=> ##3 pc == $past(pc, 4) + lsbe_pkg::PC_STEP && !taken)
    else $error("branch not skipped with carry set");

endmodule : lsbe_exec

/* lsbe_tb.sv */
// Self-checking testbench for the carry-AND, arithmetic shift and branch unit
`timescale 1ns/1ps

module testbench;
  logic        clk_i        = 1'b0;
  logic        rst_i        = 1'b1;
  logic        wb_cyc_i     = 1'b0;
  logic        wb_stb_i     = 1'b0;
  logic        wb_we_i      = 1'b0;
  logic [7:0]  wb_adr_i     = 8'h00;
  logic [3:0]  wb_sel_i     = 4'h0;
  logic [31:0] wb_dat_i     = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        busy_o;
  int          error_cnt    = 0;
  int          total_checks = 0;
  logic [15:0] seed         = 16'h0022;
  logic [15:0] mr [8];
  logic [3:0]  mf;
  logic [15:0] mpc;
  logic [1:0]  sizes [3]    = '{2'h0, 2'h2, 2'h3};

  always #50 clk_i = ~clk_i;

  lsbe_exec dut (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .busy_o   (busy_o)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic rnd(output logic [15:0] v);
    seed = lfsr(seed);
    v = seed;
  endtask : rnd

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One classic cycle, entered just after a rising edge
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rd);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) chk(32'h0, 32'h1, "ack timeout");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] rd;
    xfer(1'b1, adr, dat, rd);
    @(posedge clk_i);
  endtask : wr

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    xfer(1'b0, adr, 32'h0, rd);
    @(posedge clk_i);
    chk(rd, exp, what);
  endtask : rdchk

  task automatic setreg(input logic [2:0] i, input logic [15:0] v);
    wr({3'h0, i, 2'h0}, {16'h0000, v});
    mr[i] = v;
  endtask : setreg

  task automatic setflags(input logic [3:0] f);
    wr(lsbe_pkg::OFF_FLAGS, {28'h0, f});
    mf = f;
  endtask : setflags

  task automatic check_all(input string what);
    for (int i = 0; i < 8; i++) rdchk(8'(i * 4), {16'h0000, mr[i]}, what);
    rdchk(lsbe_pkg::OFF_FLAGS, {28'h0, mf}, what);
    rdchk(lsbe_pkg::OFF_PC, {16'h0000, mpc}, what);
  endtask : check_all

  // Writes the command, then counts the cycles busy is sampled high
  task automatic exec(input logic [31:0] cmd, input int ncyc);
    logic [31:0] rd;
    int          n;
    int          k;
    xfer(1'b1, lsbe_pkg::OFF_CMD, cmd, rd);
    n = 0;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
      if (busy_o === 1'b1) n++;
    end while ((n == 0 || busy_o === 1'b1) && k < 80);
    chk(32'(n), 32'(ncyc), "busy cycles");
  endtask : exec

  // Expected shift result into the model; returns the cycle count
  function automatic int model_shift(input lsbe_pkg::lsbe_cmd_type c);
    logic [31:0] v;
    logic [31:0] mask;
    int          m;
    int          cnt;
    logic        vf;
    logic        sgn;
    m = (c.size == 2'h0) ? 7 : (c.size == 2'h2) ? 15 : 31;
    mask = 32'hFFFFFFFF >> (31 - m);
    cnt = c.cnt_reg ? int'(mr[c.src][4:0]) :
          (c.size == 2'h3) ? int'(c.arg[4:0]) : int'(c.arg[3:0]);
    v = (c.size == 2'h3) ? {mr[c.dst | 3'h1], mr[c.dst & 3'h6]} : {16'h0000, mr[c.dst]} & mask;
    vf = (c.op == lsbe_pkg::OP_ARITH_SHIFT_LEFT) ? 1'b0 : mf[1];
    for (int i = 0; i < cnt; i++) begin
      sgn = v[m];
      if (c.op == lsbe_pkg::OP_ARITH_SHIFT_LEFT) begin
        mf[0] = v[m];
        v = (v << 1) & mask;
        if (v[m] != sgn) vf = 1'b1;
      end else begin
        mf[0] = v[0];
        v = v >> 1;
        v[m] = sgn;
      end
    end
    mf[1] = vf;
    mf[2] = v[m];
    mf[3] = (v == 32'h0);
    if (c.size == 2'h3) begin
      mr[c.dst & 3'h6] = v[15:0];
      mr[c.dst | 3'h1] = v[31:16];
    end else if (c.size == 2'h2) mr[c.dst] = v[15:0];
    else mr[c.dst][7:0] = v[7:0];
    return ((c.size == 2'h3) ? 6 : 4) + cnt / 2;
  endfunction : model_shift

  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    $display("ERROR %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    logic [15:0]            r;
    logic [31:0]            rd;
    lsbe_pkg::lsbe_cmd_type c;
    logic                   b;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (mr[i]) mr[i] = 16'h0000;
    mf = 4'h0;
    mpc = 16'h0000;
    check_all("reset");
    rdchk(lsbe_pkg::OFF_STATUS, 32'h0, "status reset");
    wr(8'h40, 32'hFFFFFFFF);
    rdchk(8'h40, 32'h0, "unmapped");
    for (int i = 0; i < 8; i++) begin
      rnd(r);
      setreg(3'(i), r);
    end
    check_all("init");
    $display("test reset done");
    for (int it = 0; it < 24; it++) begin
      rnd(r);
      setflags(r[3:0]);
      rnd(r);
      c = '0;
      c.op = it[0] ? lsbe_pkg::OP_AND_CARRY_INV_BIT : lsbe_pkg::OP_AND_CARRY_BIT;
      c.arg = {6'h00, (it >= 22) ? 3'h4 : 3'h0, r[6:0]};
      b = (it >= 22) ? 1'b0 : mr[r[6:4]][r[3:0]];
      mf[0] = mf[0] & (it[0] ? ~b : b);
      exec(c, 4);
      check_all("bit op");
    end
    $display("test carry and done");
    // Word shift by four: sign flips, then reverts
    setreg(3'h0, 16'h4000);
    setflags(4'h0);
    c = '0;
    c.op = lsbe_pkg::OP_ARITH_SHIFT_LEFT;
    c.size = lsbe_pkg::SIZE_WORD;
    c.arg = 16'h0004;
    exec(c, model_shift(c));
    check_all("sticky overflow");
    for (int it = 0; it < 60; it++) begin
      rnd(r);
      c = '0;
      c.op = r[0] ? lsbe_pkg::OP_ARITH_SHIFT_LEFT : lsbe_pkg::OP_ARITH_SHIFT_RIGHT;
      c.size = sizes[it % 3];
      c.cnt_reg = (it >= 6) && r[1];
      c.dst = r[4:2] % 3'h6;
      c.src = 3'h7;
      c.arg = (it < 6) ? 16'h0000 : {11'h000, r[15:11]};
      rnd(r);
      setreg(c.dst, r);
      rnd(r);
      setreg(c.dst ^ 3'h1, r);
      rnd(r);
      setreg(3'h7, r);
      setflags(r[3:0]);
      exec(c, model_shift(c));
      check_all("shift");
      rdchk(lsbe_pkg::OFF_FLAGS, {28'h0, mf}, "flags");
    end
    $display("test shifts done");
    for (int it = 0; it < 16; it++) begin
      rnd(r);
      setflags((it < 2) ? 4'h0 : r[3:0]);
      rnd(r);
      wr(lsbe_pkg::OFF_PC, {16'h0000, r});
      mpc = r;
      rnd(r);
      c = '0;
      c.op = lsbe_pkg::OP_BRANCH_CARRY_CLR;
      c.arg = {8'h00, (it == 0) ? 8'h7F : (it == 1) ? 8'h80 : r[7:0]};
      b = mf[0];
      mpc = mpc + 16'h0002;
      if (!b) mpc = (mpc + {{7{c.arg[7]}}, c.arg[7:0], 1'b0}) & 16'hFFFE;
      exec(c, b ? 3 : 6);
      check_all("branch");
      rdchk(lsbe_pkg::OFF_STATUS, {29'h0, 1'b0, ~b, 1'b0}, "taken");
    end
    $display("test branch done");
    c = '0;
    c.op = lsbe_pkg::OP_ARITH_SHIFT_LEFT;
    c.size = 2'h1;
    c.arg = 16'h0003;
    wr(lsbe_pkg::OFF_CMD, c);
    xfer(1'b0, lsbe_pkg::OFF_STATUS, 32'h0, rd);
    @(posedge clk_i);
    chk({31'h0, rd[2]}, 32'h1, "size error");
    check_all("no execution");
    $display("test size error done");
    end_of_test();
  end
endmodule : testbench
